//--- rtl/gspc_defines.vh
// Purpose: Constants for the global sector protect control block.
// Assumes: Status byte 1 layout with lock in bit 7 and global field in bits 5..2.
// Notes:   Included by the top design file only; definitions only.
`ifndef GSPC_DEFINES_VH
`define GSPC_DEFINES_VH

// Status byte 1 field positions.
`define GSPC_LOCK_BIT    7
`define GSPC_GLOB_HI     5
`define GSPC_GLOB_LO     2
`define GSPC_GLOB_ONES   4'hF
`define GSPC_GLOB_ZEROS  4'h0

// Opcodes of the serial commands the block decodes.
`define GSPC_OP_WREN     8'h06
`define GSPC_OP_WRDI     8'h04
`define GSPC_OP_WRSR     8'h01
`define GSPC_OP_PROT     8'h36
`define GSPC_OP_UNPROT   8'h39

// Reset values.
`define GSPC_PROT_RESET  1'b1
`define GSPC_LOCK_RESET  1'b0

// AXI4-Lite register byte offsets.
`define GSPC_REG_CTRL    8'h00
`define GSPC_REG_STATUS  8'h04
`define GSPC_REG_PROT    8'h08

// AXI response codes.
`define GSPC_RESP_OKAY   2'h0
`define GSPC_RESP_SLVERR 2'h2

`endif

//--- rtl/gspc_sync.v
// Purpose: Two flip-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to i_ref_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

module gspc_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset.
	input  wire             i_ref_clk,
	input  wire             i_rst_n,
	// Asynchronous levels in, synchronous levels out.
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta;

	////////////////////////////////////////////////////////////////////////////
	// Each bit passes two flops before anyone reads it.
	genvar b;
	generate
		for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
			always @(posedge i_ref_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta[b]   <= 1'b1;
					o_sync[b] <= 1'b1;
				end else begin
					meta[b]   <= i_async[b];
					o_sync[b] <= meta[b];
				end
			end
		end
	endgenerate

endmodule

//--- rtl/gspc_top.v
// Purpose: Global sector protect control of a serial flash, with SPI decode and AXI4-Lite view.
// Assumes: SPI mode 0/3 pins sampled by i_ref_clk well above the serial clock rate.
// Notes:   Sector bits and lock update together when chip select rises on a byte boundary.
`timescale 1ns/1ps
`include "gspc_defines.vh"

module gspc_top #(
	parameter NSECT = 4,
	parameter SECT_LSB = 16
) (
	// Clock and reset.
	input  wire             i_ref_clk,
	input  wire             i_rst_n,
	// SPI pins and write protect pin (asynchronous).
	input  wire             i_spi_sck,
	input  wire             i_spi_cs_n,
	input  wire             i_spi_mosi,
	input  wire             i_wp_n,
	// AXI4-Lite write address and data.
	input  wire [7:0]       i_awaddr,
	input  wire             i_awvalid,
	output wire             o_awready,
	input  wire [31:0]      i_wdata,
	input  wire [3:0]       i_wstrb,
	input  wire             i_wvalid,
	output wire             o_wready,
	// AXI4-Lite write response.
	output reg  [1:0]       o_bresp,
	output reg              o_bvalid,
	input  wire             i_bready,
	// AXI4-Lite read address and data.
	input  wire [7:0]       i_araddr,
	input  wire             i_arvalid,
	output wire             o_arready,
	output reg  [31:0]      o_rdata,
	output reg  [1:0]       o_rresp,
	output reg              o_rvalid,
	input  wire             i_rready,
	// Protection state to the array controller.
	output reg  [NSECT-1:0] o_sector_protect,
	output reg              o_protection_lock_bit,
	output reg              o_write_enable_latch
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.
	wire [3:0] pins;
	gspc_sync #(.WIDTH(4)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   ({i_spi_sck, i_spi_cs_n, i_spi_mosi, i_wp_n}),
		.o_sync    (pins)
	);
	wire sck  = pins[3];
	wire cs_n = pins[2];
	wire mosi = pins[1];
	wire wp_n = pins[0];

	////////////////////////////////////////////////////////////////////////////
	// Frame shifter: counts bits and keeps opcode, three further bytes.
	reg        sck_q;
	reg        cs_q;
	reg [5:0]  bitcnt;
	reg [7:0]  shreg;
	reg [7:0]  opcode;
	reg [7:0]  byte1;
	reg [23:0] addr;
	reg        overflow;
	wire       sck_rise = sck & ~sck_q;
	wire       cs_rise  = cs_n & ~cs_q;
	wire [7:0] next_shreg = {shreg[6:0], mosi};

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sck_q    <= 1'b0;
			cs_q     <= 1'b1;
			bitcnt   <= 6'h00;
			shreg    <= 8'h00;
			opcode   <= 8'h00;
			byte1    <= 8'h00;
			addr     <= 24'h000000;
			overflow <= 1'b0;
		end else begin
			sck_q <= sck;
			cs_q  <= cs_n;
			if (cs_n) begin
				bitcnt   <= 6'h00;
				overflow <= 1'b0;
			end else if (sck_rise) begin
				shreg  <= next_shreg;
				bitcnt <= bitcnt + 6'h01;
				if (bitcnt == 6'h3F)
					overflow <= 1'b1;
				if (bitcnt == 6'h07 && !overflow)
					opcode <= next_shreg;
				if (bitcnt == 6'h0F && !overflow)
					byte1 <= next_shreg;
				if (bitcnt[5:3] != 3'h0 && bitcnt[5:3] < 3'h4 && !overflow)
					addr <= {addr[22:0], mosi};
			end
		end
	end

	wire aligned = (bitcnt[2:0] == 3'h0) && (bitcnt != 6'h00 || overflow);
	wire whole1  = aligned && (bitcnt >= 6'h08 || overflow);
	wire whole2  = aligned && (bitcnt >= 6'h10 || overflow);
	wire whole4  = aligned && (bitcnt >= 6'h20 || overflow);

	////////////////////////////////////////////////////////////////////////////
	// Protection state; all updates except soft_unlock land on the rising edge of chip select.
	reg              soft_unlock;
	wire             hard_locked = ~wp_n & o_protection_lock_bit;
	wire             locked      = o_protection_lock_bit | ~soft_unlock;
	wire [3:0]       glob        = byte1[`GSPC_GLOB_HI:`GSPC_GLOB_LO];
	wire [SECT_LSB+7:0] addr_w   = addr[SECT_LSB+7:0];
	wire [7:0]       sect_idx    = addr_w[SECT_LSB+7:SECT_LSB];
	integer          i;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sector_protect      <= {NSECT{`GSPC_PROT_RESET}};
			o_protection_lock_bit <= `GSPC_LOCK_RESET;
			o_write_enable_latch  <= 1'b0;
		end else if (cs_rise) begin
			case (opcode)
				`GSPC_OP_WREN: begin
					if (whole1)
						o_write_enable_latch <= 1'b1;
				end
				`GSPC_OP_WRDI: begin
					if (whole1)
						o_write_enable_latch <= 1'b0;
				end
				`GSPC_OP_WRSR: begin
					// Write status byte one, only with the latch set.
					if (whole2 && o_write_enable_latch && !hard_locked) begin
						o_protection_lock_bit <= byte1[`GSPC_LOCK_BIT];
						if (!o_protection_lock_bit && glob == `GSPC_GLOB_ONES)
							o_sector_protect <= {NSECT{1'b1}};
						else if (!o_protection_lock_bit && glob == `GSPC_GLOB_ZEROS)
							o_sector_protect <= {NSECT{1'b0}};
						// Mixed patterns keep the present sector bits.
					end
					if (whole1)
						o_write_enable_latch <= 1'b0;
				end
				`GSPC_OP_PROT, `GSPC_OP_UNPROT: begin
					// Single sector commands act only with four whole bytes, the latch set and the lock bit clear.
					if (whole4 && o_write_enable_latch && !o_protection_lock_bit) begin
						for (i = 0; i < NSECT; i = i + 1)
							if (sect_idx == i[7:0])
								o_sector_protect[i] <= (opcode == `GSPC_OP_PROT);
					end
					if (whole1)
						o_write_enable_latch <= 1'b0;
				end
				default: begin
					o_write_enable_latch <= o_write_enable_latch;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: a write proceeds once address and data are both present.
	wire      wr_go = i_awvalid & i_wvalid & ~o_bvalid;
	assign o_awready = wr_go;
	assign o_wready  = wr_go;
	assign o_arready = ~o_rvalid;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bvalid    <= 1'b0;
			o_bresp     <= `GSPC_RESP_OKAY;
			soft_unlock <= 1'b0;
		end else begin
			if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
			if (wr_go) begin
				o_bvalid <= 1'b1;
				if (i_awaddr == `GSPC_REG_CTRL) begin
					o_bresp <= `GSPC_RESP_OKAY;
					if (i_wstrb[0])
						soft_unlock <= i_wdata[0];
				end else if (i_awaddr == `GSPC_REG_STATUS || i_awaddr == `GSPC_REG_PROT)
					o_bresp <= `GSPC_RESP_OKAY;
				else
					o_bresp <= `GSPC_RESP_SLVERR;
			end
		end
	end

	// Read path: one cycle after the address is taken.
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h00000000;
			o_rresp  <= `GSPC_RESP_OKAY;
		end else if (o_rvalid) begin
			if (i_rready)
				o_rvalid <= 1'b0;
		end else if (i_arvalid) begin
			o_rvalid <= 1'b1;
			o_rresp  <= `GSPC_RESP_OKAY;
			case (i_araddr)
				`GSPC_REG_CTRL:   o_rdata <= {31'h00000000, soft_unlock};
				`GSPC_REG_STATUS: o_rdata <= {28'h0000000, locked, wp_n, o_protection_lock_bit,
					o_write_enable_latch};
				`GSPC_REG_PROT:   o_rdata <= {{(32-NSECT){1'b0}}, o_sector_protect};
				default: begin
					o_rdata <= 32'h00000000;
					o_rresp <= `GSPC_RESP_SLVERR;
				end
			endcase
		end
	end

endmodule

//--- test/gspc_chk.sv
// Purpose: Port assertions of the global sector protect block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module gspc_chk #(parameter NSECT = 4) (
	// Watched ports.
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_spi_cs_n,
	input wire logic i_wp_n,
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic o_bvalid,
	input wire logic [NSECT-1:0] o_sector_protect,
	input wire logic o_protection_lock_bit,
	input wire logic o_write_enable_latch
);
	// One clock and one reset for every property.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rst; $rose(i_rst_n) |-> &o_sector_protect; endproperty
	a_rst: assert property (p_rst) else $error("sectors open at reset");
	property p_cs; $changed(o_sector_protect) |-> $past(i_spi_cs_n, 2); endproperty
	a_cs: assert property (p_cs) else $error("sectors changed in frame");
	property p_lcs; $changed(o_protection_lock_bit) |-> $past(i_spi_cs_n, 2); endproperty
	a_lcs: assert property (p_lcs) else $error("lock changed in frame");
	// The design sees the pin two flops late, so the level that gates an update is the one two edges back.
	property p_hard; o_protection_lock_bit && !$past(i_wp_n, 2) |=> o_protection_lock_bit; endproperty
	a_hard: assert property (p_hard) else $error("hard lock cleared");
	property p_lock; o_protection_lock_bit |=> $stable(o_sector_protect); endproperty
	a_lock: assert property (p_lock) else $error("locked sectors changed");
	property p_wel; $changed(o_sector_protect) |-> $fell(o_write_enable_latch); endproperty
	a_wel: assert property (p_wel) else $error("latch not consumed");
	property p_pat; $changed(o_sector_protect) |-> &o_sector_protect || o_sector_protect == 0
		|| $onehot(o_sector_protect ^ $past(o_sector_protect)); endproperty
	a_pat: assert property (p_pat) else $error("partial global change");
	property p_aw; i_awvalid && i_wvalid && !o_bvalid |=> o_bvalid; endproperty
	a_aw: assert property (p_aw) else $error("write not answered");
endmodule

//--- test/gspc_host.sv
// Purpose: SPI host model for the global sector protect block.
// Assumes: Mode 0, four clocks per serial clock phase.
// Notes:   Data line inverts while deselected.
`timescale 1ns/1ps
module gspc_host (
	// Clock and serial pins.
	input wire logic i_ref_clk,
	output logic o_spi_sck = 1'b0,
	output logic o_spi_cs_n = 1'b1,
	output logic o_spi_mosi = 1'b0
);
	// Sends the low n bits of d, most significant first.
	task automatic frame(input logic [31:0] d, input int n);
		o_spi_cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_spi_mosi <= d[i];
			repeat (4) @(posedge i_ref_clk);
			o_spi_sck <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			o_spi_sck <= 1'b0;
		end
		repeat (4) @(posedge i_ref_clk);
		o_spi_cs_n <= 1'b1;
		o_spi_mosi <= ~o_spi_mosi;
		repeat (8) @(posedge i_ref_clk);
	endtask
endmodule

//--- test/gspc_tb_top.sv
// Purpose: Self-checking bench of the global sector protect block.
// Assumes: Host model drives the serial pins; bench is the bus master.
// Notes:   Each scenario task checks its own results.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; $display("unexpected %s %0h %0h", n, e, a); end end
module gspc_tb_top;
	logic i_ref_clk = 1'b0, i_rst_n, i_wp_n, i_spi_sck, i_spi_cs_n, i_spi_mosi, o_awready, o_wready, o_bvalid;
	logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, o_arready, o_rvalid, o_protection_lock_bit, o_write_enable_latch;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [3:0] i_wstrb, o_sector_protect;
	logic [1:0] o_bresp, o_rresp, bq, rq;
	int num_errors = 0, comparisons = 0;
	gspc_top dut_u (.i_ref_clk, .i_rst_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi, .i_wp_n, .i_awaddr, .i_awvalid, .o_awready,
		.i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_sector_protect, .o_protection_lock_bit, .o_write_enable_latch);
	gspc_host host_u (.i_ref_clk, .o_spi_sck(i_spi_sck), .o_spi_cs_n(i_spi_cs_n), .o_spi_mosi(i_spi_mosi));
	// Free-running 40 ns clock.
	initial forever #20 i_ref_clk = ~i_ref_clk;
	// Sets the write latch, then writes status byte one.
	task automatic wrsr(input logic [7:0] b);
		host_u.frame(32'h06, 8);
		host_u.frame({8'h01, b}, 16);
	endtask
	// Writes one word to an address, then reads that address.
	task automatic axi(input logic [7:0] a);
		logic aw_open;
		logic w_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		{i_awaddr, i_araddr} <= {a, a};
		{i_awvalid, i_wvalid, i_bready} <= 3'h7;
		// Each channel is released at the edge at which its own ready is seen high.
		while (aw_open || w_open) begin
			@(posedge i_ref_clk);
			if (aw_open && o_awready === 1'b1) begin
				aw_open = 1'b0;
				i_awvalid <= 1'b0;
			end
			if (w_open && o_wready === 1'b1) begin
				w_open = 1'b0;
				i_wvalid <= 1'b0;
			end
		end
		do @(posedge i_ref_clk); while (o_bvalid !== 1'b1);
		bq = o_bresp;
		{i_bready, i_arvalid, i_rready} <= 3'h3;
		do @(posedge i_ref_clk); while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
		do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
		{rq, rd} = {o_rresp, o_rdata};
		i_rready <= 1'b0;
	endtask
	// Power-up view, global unprotect, mixed pattern, short frame, global protect.
	task automatic t_global;
		axi(8'h08);
		`CHK("power-up", 34'h0000_000F, {bq, rd})
		axi(8'h0C);
		`CHK("unmapped", 4'hA, {bq, rq})
		wrsr(8'h00);
		`CHK("unprotect", 5'h00, {o_sector_protect, o_write_enable_latch})
		wrsr(8'h1C);
		`CHK("mixed", 4'h0, o_sector_protect)
		host_u.frame(32'h06, 8);
		host_u.frame(32'h01F, 12);
		`CHK("short", 5'h01, {o_sector_protect, o_write_enable_latch})
		wrsr(8'h3C);
		`CHK("protect", 4'hF, o_sector_protect)
	endtask
	// Single sector command, lock set with a global action, then hard lock.
	task automatic t_lock;
		host_u.frame(32'h06, 8);
		host_u.frame(32'h39020000, 32);
		`CHK("sector", 4'hB, o_sector_protect)
		wrsr(8'h80);
		`CHK("lock", 5'h10, {o_protection_lock_bit, o_sector_protect})
		i_wp_n <= 1'b0;
		wrsr(8'h3C);
		`CHK("hard lock", 5'h10, {o_protection_lock_bit, o_sector_protect})
	endtask
	// Register view, lock release with the pin high, write disable, single protect.
	task automatic t_regs;
		axi(8'h04);
		`CHK("status", 34'h0_0000_000A, {bq, rd})
		axi(8'h00);
		`CHK("ctrl", 34'h0_0000_0001, {bq, rd})
		i_wp_n <= 1'b1;
		wrsr(8'h3C);
		`CHK("soft lock", 6'h00, {o_protection_lock_bit, o_write_enable_latch, o_sector_protect})
		host_u.frame(32'h06, 8);
		host_u.frame(32'h04, 8);
		host_u.frame(32'h36010000, 32);
		`CHK("no latch", 5'h00, {o_write_enable_latch, o_sector_protect})
		host_u.frame(32'h06, 8);
		host_u.frame(32'h36010000, 32);
		`CHK("protect one", 5'h02, {o_write_enable_latch, o_sector_protect})
		axi(8'h04);
		`CHK("status open", 34'h0_0000_0004, {bq, rd})
	endtask
	// Reset in mid-run with the latch set: every sector returns to protected.
	task automatic t_reset;
		host_u.frame(32'h06, 8);
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		`CHK("reset", 6'h0F, {o_protection_lock_bit, o_write_enable_latch, o_sector_protect})
	endtask
	// Reset, scenarios, verdict.
	initial begin
		{i_rst_n, i_wp_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h20;
		{i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h1F;
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		t_global;
		t_lock;
		t_regs;
		t_reset;
		stop_test;
	end
	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		num_errors++;
		stop_test;
	end
	// Prints the counts and the verdict.
	task automatic stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
endmodule
bind gspc_top gspc_chk #(.NSECT(NSECT)) chk_u (.i_ref_clk, .i_rst_n, .i_spi_cs_n, .i_wp_n, .i_awvalid, .i_wvalid,
	.o_bvalid, .o_sector_protect, .o_protection_lock_bit, .o_write_enable_latch);
